//--- rtl/rplat_top.sv
// Client datapath and latency measurement core for one channel of the radio link port.
// Assumes all client words arrive on CORE_CLK_IN, markers from the line side async.
`timescale 1ns/1ps
`default_nettype none
module rplat_top #(
    parameter int TX_PIPE = 2
) (
    input  wire logic                                CORE_CLK_IN,
    input  wire logic                                RST_N_IN,
    input  wire logic                                LEGACY_MODE_IN,
    input  wire logic [rplat_pkg::MII_DATA_W-1:0]   TX_CLIENT_DATA_IN,
    input  wire logic [rplat_pkg::MII_CTRL_W-1:0]   TX_CLIENT_CTRL_IN,
    input  wire logic [rplat_pkg::LEG_DATA_W-1:0]   TX_LEGACY_CODE_DATA_IN,
    input  wire logic [rplat_pkg::LEG_CTRL_W-1:0]   TX_LEGACY_CODE_CTRL_IN,
    output logic      [rplat_pkg::MII_DATA_W-1:0]   TX_LINE_DATA_OUT,
    output logic      [rplat_pkg::MII_CTRL_W-1:0]   TX_LINE_CTRL_OUT,
    input  wire logic [rplat_pkg::MII_DATA_W-1:0]   RX_LINE_DATA_IN,
    input  wire logic [rplat_pkg::MII_CTRL_W-1:0]   RX_LINE_CTRL_IN,
    output logic      [rplat_pkg::MII_DATA_W-1:0]   RX_CLIENT_DATA_OUT,
    output logic      [rplat_pkg::MII_CTRL_W-1:0]   RX_CLIENT_CTRL_OUT,
    output logic      [rplat_pkg::LEG_DATA_W-1:0]   RX_LEGACY_CODE_DATA_OUT,
    output logic      [rplat_pkg::LEG_CTRL_W-1:0]   RX_LEGACY_CODE_CTRL_OUT,
    output logic                                     CTRL_MARK_ERR_OUT,
    input  wire logic                                TX_MARK_START_IN,
    input  wire logic                                TX_MARK_END_IN,
    input  wire logic                                RX_MARK_START_IN,
    input  wire logic                                RX_MARK_END_IN,
    input  wire logic [rplat_pkg::BLK_SLIP_W-1:0]   RX_SLIP_COUNT_FAST_IN,
    input  wire logic [rplat_pkg::CW_SLIP_W-1:0]    RX_CODEWORD_OFFSET_IN,
    input  wire logic                                LINK_UP_IN,
    input  wire logic                                CFG_WRITE_IN,
    input  wire logic                                CFG_READ_IN,
    input  wire logic [rplat_pkg::ADDR_W-1:0]       CFG_ADDR_IN,
    input  wire logic [rplat_pkg::RDATA_W-1:0]      CFG_WDATA_IN,
    output logic      [rplat_pkg::RDATA_W-1:0]      CFG_RDATA_OUT,
    output logic                                     CFG_RVALID_OUT,
    output logic      [rplat_pkg::REFSEL_W-1:0]     REFCLK_SELECT_OUT
);
    import rplat_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Marker synchronisers.

    logic [3:0] mark_raw;
    logic [3:0] mark_sync;
    assign mark_raw = {RX_MARK_END_IN, RX_MARK_START_IN, TX_MARK_END_IN, TX_MARK_START_IN};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            rplat_sync u_sync (
                .clk_in   (CORE_CLK_IN),
                .rst_n_in (RST_N_IN),
                .d_in     (mark_raw[gi]),
                .q_out    (mark_sync[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Delay measurement, one counter per direction.

    rplat_meas_t             tx_state_reg;
    rplat_meas_t             tx_state_next;
    rplat_meas_t             rx_state_reg;
    rplat_meas_t             rx_state_next;
    logic [DELAY_W-1:0]      tx_delay_cycles_reg;
    logic [DELAY_W-1:0]      tx_delay_cycles_next;
    logic [DELAY_W-1:0]      rx_delay_cycles_reg;
    logic [DELAY_W-1:0]      rx_delay_cycles_next;
    logic [3:0]              mark_prev_reg;
    logic [3:0]              mark_rise;

    assign mark_rise = mark_sync & ~mark_prev_reg;

    // One whole cycle is one unit of the integer part; the fraction is left zero because
    // the core clock cannot resolve sub-cycle phase.
    function automatic rplat_meas_t meas_step(input rplat_meas_t st, input logic start, input logic stop);
        rplat_meas_t nx;
        nx = st;
        case (st)
            RPLAT_IDLE: if (start) nx = RPLAT_RUN;
            RPLAT_RUN:  if (stop) nx = RPLAT_DONE;
            RPLAT_DONE: if (start) nx = RPLAT_RUN;
            default:    nx = RPLAT_IDLE;
        endcase
        return nx;
    endfunction

    function automatic logic [DELAY_W-1:0] meas_count(input rplat_meas_t st, input logic start,
                                                      input logic [DELAY_W-1:0] cnt);
        logic [DELAY_W-1:0] nx;
        nx = cnt;
        if (start && st != RPLAT_RUN) begin
            nx = '0;
        end else if (st == RPLAT_RUN && cnt[DELAY_W-1:FRAC_W] != '1) begin
            nx = cnt + DELAY_W'(1 << FRAC_W);
        end
        return nx;
    endfunction

    always_comb begin
        tx_state_next        = meas_step(tx_state_reg, mark_rise[0], mark_rise[1]);
        rx_state_next        = meas_step(rx_state_reg, mark_rise[2], mark_rise[3]);
        tx_delay_cycles_next = meas_count(tx_state_reg, mark_rise[0], tx_delay_cycles_reg);
        rx_delay_cycles_next = meas_count(rx_state_reg, mark_rise[2], rx_delay_cycles_reg);
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            tx_state_reg        <= RPLAT_IDLE;
            rx_state_reg        <= RPLAT_IDLE;
            tx_delay_cycles_reg <= '0;
            rx_delay_cycles_reg <= '0;
            mark_prev_reg       <= 4'h0;
        end else begin
            tx_state_reg        <= tx_state_next;
            rx_state_reg        <= rx_state_next;
            tx_delay_cycles_reg <= tx_delay_cycles_next;
            rx_delay_cycles_reg <= rx_delay_cycles_next;
            mark_prev_reg       <= mark_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Slip counts held per link-up.

    logic [BLK_SLIP_W-1:0] slip_fast_reg;
    logic [BLK_SLIP_W-1:0] slip_fast_next;
    logic [CW_SLIP_W-1:0]  cw_off_reg;
    logic [CW_SLIP_W-1:0]  cw_off_next;
    logic                  link_prev_reg;

    // Sampled once at link-up so the value stays fixed while the link is up.
    always_comb begin
        slip_fast_next = slip_fast_reg;
        cw_off_next    = cw_off_reg;
        if (LINK_UP_IN && !link_prev_reg) begin
            slip_fast_next = RX_SLIP_COUNT_FAST_IN;
            cw_off_next    = RX_CODEWORD_OFFSET_IN;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            slip_fast_reg <= '0;
            cw_off_reg    <= '0;
            link_prev_reg <= 1'b0;
        end else begin
            slip_fast_reg <= slip_fast_next;
            cw_off_reg    <= cw_off_next;
            link_prev_reg <= LINK_UP_IN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Register port: reference select and read-back.

    logic [REFSEL_W-1:0] refsel_reg;
    logic [REFSEL_W-1:0] refsel_next;
    logic [RDATA_W-1:0]  rdata_reg;
    logic [RDATA_W-1:0]  rdata_next;
    logic                rvalid_reg;
    logic                rvalid_next;

    always_comb begin
        refsel_next = refsel_reg;
        rdata_next  = rdata_reg;
        rvalid_next = CFG_READ_IN;
        // Out of range selections are ignored so exactly one reference stays selected.
        if (CFG_WRITE_IN && CFG_ADDR_IN == ADDR_REFSEL &&
            CFG_WDATA_IN < RDATA_W'(NUM_REFCLK)) begin
            refsel_next = CFG_WDATA_IN[REFSEL_W-1:0];
        end
        if (CFG_READ_IN) begin
            if (CFG_ADDR_IN == ADDR_TX_DELAY) begin
                rdata_next = {{(RDATA_W-DELAY_W){1'b0}}, tx_delay_cycles_reg};
            end else if (CFG_ADDR_IN == ADDR_RX_DELAY) begin
                rdata_next = {{(RDATA_W-DELAY_W){1'b0}}, rx_delay_cycles_reg};
            end else if (CFG_ADDR_IN == ADDR_BLK_SLIP) begin
                rdata_next = {{(RDATA_W-BLK_SLIP_W){1'b0}}, slip_fast_reg};
            end else if (CFG_ADDR_IN == ADDR_CW_SLIP) begin
                rdata_next = {{(RDATA_W-CW_SLIP_W){1'b0}}, cw_off_reg};
            end else if (CFG_ADDR_IN == ADDR_REFSEL) begin
                rdata_next = {{(RDATA_W-REFSEL_W){1'b0}}, refsel_reg};
            end else begin
                rdata_next = '0;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            refsel_reg <= REFSEL_RESET;
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            refsel_reg <= refsel_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign CFG_RDATA_OUT     = rdata_reg;
    assign CFG_RVALID_OUT    = rvalid_reg;
    assign REFCLK_SELECT_OUT = refsel_reg;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Client datapath.

    // A start or end code byte flagged as data is reported, not corrected.
    function automatic logic marks_bad(input logic [MII_DATA_W-1:0] d, input logic [MII_CTRL_W-1:0] c,
                                       input logic legacy);
        logic bad;
        bad = 1'b0;
        for (int i = 0; i < MII_CTRL_W; i++) begin
            if ((!legacy || i < LEG_CTRL_W) && !c[i] &&
                (d[i*BYTE_W +: BYTE_W] == CODE_START || d[i*BYTE_W +: BYTE_W] == CODE_END)) begin
                bad = 1'b1;
            end
        end
        return bad;
    endfunction

    logic [MII_DATA_W-1:0] tx_d_reg;
    logic [MII_DATA_W-1:0] tx_d_next;
    logic [MII_CTRL_W-1:0] tx_c_reg;
    logic [MII_CTRL_W-1:0] tx_c_next;
    logic [MII_DATA_W-1:0] rx_d_reg;
    logic [MII_DATA_W-1:0] rx_d_next;
    logic [MII_CTRL_W-1:0] rx_c_reg;
    logic [MII_CTRL_W-1:0] rx_c_next;
    logic                  err_reg;
    logic                  err_next;

    // The core clock stands in for the divide-by-66 client clock that times both client ports.
    always_comb begin
        // Legacy words use the low lanes; byte 7:0 stays the first byte on the line.
        if (LEGACY_MODE_IN) begin
            tx_d_next = {{(MII_DATA_W-LEG_DATA_W){1'b0}}, TX_LEGACY_CODE_DATA_IN};
            tx_c_next = {{(MII_CTRL_W-LEG_CTRL_W){1'b0}}, TX_LEGACY_CODE_CTRL_IN};
        end else begin
            tx_d_next = TX_CLIENT_DATA_IN;
            tx_c_next = TX_CLIENT_CTRL_IN;
        end
        rx_d_next = RX_LINE_DATA_IN;
        rx_c_next = RX_LINE_CTRL_IN;
        err_next  = marks_bad(tx_d_next, tx_c_next, LEGACY_MODE_IN) ||
                    marks_bad(RX_LINE_DATA_IN, RX_LINE_CTRL_IN, LEGACY_MODE_IN);
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            tx_d_reg <= '0;
            tx_c_reg <= '0;
            rx_d_reg <= '0;
            rx_c_reg <= '0;
            err_reg  <= 1'b0;
        end else begin
            tx_d_reg <= tx_d_next;
            tx_c_reg <= tx_c_next;
            rx_d_reg <= rx_d_next;
            rx_c_reg <= rx_c_next;
            err_reg  <= err_next;
        end
    end

    assign TX_LINE_DATA_OUT        = tx_d_reg;
    assign TX_LINE_CTRL_OUT        = tx_c_reg;
    assign RX_CLIENT_DATA_OUT      = rx_d_reg;
    assign RX_CLIENT_CTRL_OUT      = rx_c_reg;
    assign RX_LEGACY_CODE_DATA_OUT = rx_d_reg[LEG_DATA_W-1:0];
    assign RX_LEGACY_CODE_CTRL_OUT = rx_c_reg[LEG_CTRL_W-1:0];
    assign CTRL_MARK_ERR_OUT       = err_reg;
endmodule
`default_nettype wire

//--- rtl/rplat_pkg.sv
// Constants for the radio link client port and latency block.
// Assumes a single 200 MHz core clock and software that converts delay values to time.
// Functional notes
// - Transmit delay in sampling cycles sits in bits 20:0 of register tx_path_delay.
// - Receive delay in sampling cycles sits in bits 20:0 of register rx_path_delay.
// - Delays are unsigned fixed point, 13 integer bits and 8 fraction bits.
// - Block alignment slip count sits in bits 6:0 of register rx_block_slip_count, fixed per link-up.
// - Codeword alignment slip count sits in bits 4:0 of register rx_codeword_slip_count, fixed per link-up.
// - Each channel selects one of five reference clocks, default zero, via reconfiguration.
// - Device gives parallel clocks at line rate over 64 and 66; 66 times client ports.
// - Each control bit marks its byte as control; start and end bytes are control.
// - Device delivers received 64 plus 8 bit words in the transmit client timing.
// - The 8b/10b transmit port carries 16 data and 2 control bits, low byte first.
// - In 8b/10b mode device delivers 16 data and 2 control received bits.

package rplat_pkg;
    localparam int          MII_DATA_W    = 64;
    localparam int          MII_CTRL_W    = 8;
    localparam int          LEG_DATA_W    = 16;
    localparam int          LEG_CTRL_W    = 2;
    localparam int          BYTE_W        = 8;
    localparam int          ADDR_W        = 12;
    localparam int          RDATA_W       = 32;
    localparam int          DELAY_W       = 21;
    localparam int          FRAC_W        = 8;
    localparam int          REFSEL_W      = 3;
    localparam int          NUM_REFCLK    = 5;
    localparam int          DIV_FAST      = 64;
    localparam int          DIV_SLOW      = 66;
    localparam int          SYNC_DEPTH    = 3;
    localparam logic [11:0] ADDR_TX_DELAY = 12'hC02;
    localparam logic [11:0] ADDR_RX_DELAY = 12'hC03;
    localparam logic [11:0] ADDR_BLK_SLIP = 12'h028;
    localparam logic [11:0] ADDR_CW_SLIP  = 12'h029;
    localparam logic [11:0] ADDR_REFSEL   = 12'h02A;
    localparam int          BLK_SLIP_W    = 7;
    localparam int          CW_SLIP_W     = 5;
    localparam logic [2:0]  REFSEL_RESET  = 3'h0;
    localparam logic [7:0]  CODE_START    = 8'hFB;
    localparam logic [7:0]  CODE_END     = 8'hFD;
    localparam logic [7:0]  FRAC_ONE_CYC  = 8'hFF;
    typedef enum logic [1:0] {RPLAT_IDLE, RPLAT_RUN, RPLAT_DONE} rplat_meas_t;
endpackage

//--- rtl/rplat_sync.sv
// Three-stage synchroniser with agreement filter for one level.
// Assumes the input is asynchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module rplat_sync (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic d_in,
    output logic      q_out
);
    logic [2:0] stage_reg;
    logic [2:0] stage_next;
    logic       q_reg;
    logic       q_next;

    always_comb begin
        stage_next = {stage_reg[1:0], d_in};
        q_next     = (stage_reg[2] == stage_reg[1]) ? stage_reg[1] : q_reg;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage_reg <= 3'h0;
            q_reg     <= 1'b0;
        end else begin
            stage_reg <= stage_next;
            q_reg     <= q_next;
        end
    end

    assign q_out = q_reg;
endmodule
`default_nettype wire

//--- test/rplat_top_sva.sv
// Checker for the client datapath and register port of the latency block.
// Assumes it is bound to rplat_top and shares its single core clock and reset.
`timescale 1ns/1ps
`default_nettype none
module rplat_top_sva #(
    parameter int TX_PIPE = 2
) (
    input wire logic                              CORE_CLK_IN,
    input wire logic                              RST_N_IN,
    input wire logic                              LEGACY_MODE_IN,
    input wire logic [rplat_pkg::MII_DATA_W-1:0] TX_CLIENT_DATA_IN,
    input wire logic [rplat_pkg::MII_CTRL_W-1:0] TX_CLIENT_CTRL_IN,
    input wire logic [rplat_pkg::LEG_DATA_W-1:0] TX_LEGACY_CODE_DATA_IN,
    input wire logic [rplat_pkg::LEG_CTRL_W-1:0] TX_LEGACY_CODE_CTRL_IN,
    input wire logic [rplat_pkg::MII_DATA_W-1:0] TX_LINE_DATA_OUT,
    input wire logic [rplat_pkg::MII_CTRL_W-1:0] TX_LINE_CTRL_OUT,
    input wire logic [rplat_pkg::MII_DATA_W-1:0] RX_LINE_DATA_IN,
    input wire logic [rplat_pkg::MII_CTRL_W-1:0] RX_LINE_CTRL_IN,
    input wire logic [rplat_pkg::MII_DATA_W-1:0] RX_CLIENT_DATA_OUT,
    input wire logic [rplat_pkg::MII_CTRL_W-1:0] RX_CLIENT_CTRL_OUT,
    input wire logic [rplat_pkg::LEG_DATA_W-1:0] RX_LEGACY_CODE_DATA_OUT,
    input wire logic [rplat_pkg::LEG_CTRL_W-1:0] RX_LEGACY_CODE_CTRL_OUT,
    input wire logic                              CTRL_MARK_ERR_OUT,
    input wire logic                              CFG_WRITE_IN,
    input wire logic                              CFG_READ_IN,
    input wire logic [rplat_pkg::ADDR_W-1:0]     CFG_ADDR_IN,
    input wire logic [rplat_pkg::RDATA_W-1:0]    CFG_WDATA_IN,
    input wire logic [rplat_pkg::RDATA_W-1:0]    CFG_RDATA_OUT,
    input wire logic                              CFG_RVALID_OUT,
    input wire logic [rplat_pkg::REFSEL_W-1:0]   REFCLK_SELECT_OUT
);
    import rplat_pkg::*;
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    ////////////////////////////////////////////////////////////////////////////////
    tx_word_a: assert property (!LEGACY_MODE_IN |=> TX_LINE_DATA_OUT == $past(TX_CLIENT_DATA_IN)
        && TX_LINE_CTRL_OUT == $past(TX_CLIENT_CTRL_IN)) else $error("tx word not passed");
    legacy_word_a: assert property (LEGACY_MODE_IN |=> TX_LINE_DATA_OUT == {48'h0, $past(TX_LEGACY_CODE_DATA_IN)}
        && TX_LINE_CTRL_OUT == {6'h00, $past(TX_LEGACY_CODE_CTRL_IN)}) else $error("legacy word not passed");
    rx_word_a: assert property (1'b1 |=> RX_CLIENT_DATA_OUT == $past(RX_LINE_DATA_IN)
        && RX_CLIENT_CTRL_OUT == $past(RX_LINE_CTRL_IN)) else $error("rx word not passed");
    rx_legacy_lanes_a: assert property (RX_LEGACY_CODE_DATA_OUT == RX_CLIENT_DATA_OUT[15:0]
        && RX_LEGACY_CODE_CTRL_OUT == RX_CLIENT_CTRL_OUT[1:0]) else $error("rx legacy lanes differ");
    read_answer_a: assert property (1'b1 |=> CFG_RVALID_OUT == $past(CFG_READ_IN))
        else $error("read answer timing wrong");
    delay_format_a: assert property (CFG_READ_IN && (CFG_ADDR_IN == ADDR_TX_DELAY || CFG_ADDR_IN == ADDR_RX_DELAY)
        |=> CFG_RDATA_OUT[31:21] == 11'h000 && CFG_RDATA_OUT[7:0] == 8'h00) else $error("delay format wrong");
    block_slip_width_a: assert property (CFG_READ_IN && CFG_ADDR_IN == ADDR_BLK_SLIP
        |=> CFG_RDATA_OUT[31:7] == 25'h0) else $error("block slip too wide");
    cw_slip_width_a: assert property (CFG_READ_IN && CFG_ADDR_IN == ADDR_CW_SLIP
        |=> CFG_RDATA_OUT[31:5] == 27'h0) else $error("codeword slip too wide");
    refsel_write_a: assert property (CFG_WRITE_IN && CFG_ADDR_IN == ADDR_REFSEL && CFG_WDATA_IN < NUM_REFCLK
        |=> REFCLK_SELECT_OUT == 3'($past(CFG_WDATA_IN))) else $error("refsel write lost");
    refsel_hold_a: assert property (!(CFG_WRITE_IN && CFG_ADDR_IN == ADDR_REFSEL && CFG_WDATA_IN < NUM_REFCLK)
        |=> $stable(REFCLK_SELECT_OUT) && REFCLK_SELECT_OUT < 3'h5) else $error("refsel changed");
    mark_err_a: assert property (!LEGACY_MODE_IN && TX_CLIENT_DATA_IN[7:0] == CODE_START && !TX_CLIENT_CTRL_IN[0]
        |=> CTRL_MARK_ERR_OUT) else $error("start byte as data not flagged");
    cover property (CFG_WRITE_IN && CFG_ADDR_IN == ADDR_REFSEL);
    cover property (CTRL_MARK_ERR_OUT);
    cover property (LEGACY_MODE_IN);
endmodule
bind rplat_top rplat_top_sva #(.TX_PIPE(TX_PIPE)) u_sva (.CORE_CLK_IN, .RST_N_IN, .LEGACY_MODE_IN, .TX_CLIENT_DATA_IN,
    .TX_CLIENT_CTRL_IN, .TX_LEGACY_CODE_DATA_IN, .TX_LEGACY_CODE_CTRL_IN, .TX_LINE_DATA_OUT, .TX_LINE_CTRL_OUT,
    .RX_LINE_DATA_IN, .RX_LINE_CTRL_IN, .RX_CLIENT_DATA_OUT, .RX_CLIENT_CTRL_OUT, .RX_LEGACY_CODE_DATA_OUT,
    .RX_LEGACY_CODE_CTRL_OUT, .CTRL_MARK_ERR_OUT, .CFG_WRITE_IN, .CFG_READ_IN, .CFG_ADDR_IN, .CFG_WDATA_IN,
    .CFG_RDATA_OUT, .CFG_RVALID_OUT, .REFCLK_SELECT_OUT);
`default_nettype wire

//--- test/rplat_framer.sv
// Client framer model that offers transmit words to the block.
// Assumes the bench changes the word kind shortly after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module rplat_framer (
    input  wire logic [1:0]  kind_in,
    output logic      [63:0] data_out,
    output logic      [7:0]  ctrl_out
);
    import rplat_pkg::*;
    // Kind 3 flags a start byte as data on purpose, to provoke the marker error.
    always_comb begin
        case (kind_in)
            2'h0:    begin data_out = {56'hD5555555555555, CODE_START}; ctrl_out = 8'h01; end
            2'h1:    begin data_out = 64'h0123456789ABCDEF; ctrl_out = 8'h00; end
            2'h2:    begin data_out = {56'h07070707070707, CODE_END}; ctrl_out = 8'hFF; end
            default: begin data_out = {56'h0, CODE_START}; ctrl_out = 8'h00; end
        endcase
    end
endmodule
`default_nettype wire

//--- test/radio_phy_client_port_latency_test.sv
// Self-checking bench for the client datapath, delay measurement and registers.
// Assumes rplat_top runs on one 200 MHz core clock with markers as slow levels.
`timescale 1ns/1ps
`default_nettype none
module radio_phy_client_port_latency_test;
    import rplat_pkg::*;
    logic        CORE_CLK_IN = 1'b0, RST_N_IN, LEGACY_MODE_IN, LINK_UP_IN, CFG_WRITE_IN, CFG_READ_IN;
    logic        TX_MARK_START_IN, TX_MARK_END_IN, RX_MARK_START_IN, RX_MARK_END_IN, CTRL_MARK_ERR_OUT, CFG_RVALID_OUT;
    logic [63:0] TX_CLIENT_DATA_IN, TX_LINE_DATA_OUT, RX_LINE_DATA_IN, RX_CLIENT_DATA_OUT;
    logic [7:0]  TX_CLIENT_CTRL_IN, TX_LINE_CTRL_OUT, RX_LINE_CTRL_IN, RX_CLIENT_CTRL_OUT;
    logic [15:0] TX_LEGACY_CODE_DATA_IN, RX_LEGACY_CODE_DATA_OUT;
    logic [1:0]  TX_LEGACY_CODE_CTRL_IN, RX_LEGACY_CODE_CTRL_OUT, kind;
    logic [6:0]  RX_SLIP_COUNT_FAST_IN;
    logic [4:0]  RX_CODEWORD_OFFSET_IN;
    logic [11:0] CFG_ADDR_IN;
    logic [31:0] CFG_WDATA_IN, CFG_RDATA_OUT;
    logic [2:0]  REFCLK_SELECT_OUT;
    int          fails = 0, n_tests = 0;
    assign TX_LEGACY_CODE_DATA_IN = TX_CLIENT_DATA_IN[15:0];
    assign TX_LEGACY_CODE_CTRL_IN = TX_CLIENT_CTRL_IN[1:0];
    // One clock stands in for the sampling, datapath, reference, bridge and configuration clocks.
    always #2.5 CORE_CLK_IN = ~CORE_CLK_IN;
    rplat_framer framer (.kind_in(kind), .data_out(TX_CLIENT_DATA_IN), .ctrl_out(TX_CLIENT_CTRL_IN));
    rplat_top uut (.CORE_CLK_IN, .RST_N_IN, .LEGACY_MODE_IN, .TX_CLIENT_DATA_IN, .TX_CLIENT_CTRL_IN,
        .TX_LEGACY_CODE_DATA_IN, .TX_LEGACY_CODE_CTRL_IN, .TX_LINE_DATA_OUT, .TX_LINE_CTRL_OUT, .RX_LINE_DATA_IN,
        .RX_LINE_CTRL_IN, .RX_CLIENT_DATA_OUT, .RX_CLIENT_CTRL_OUT, .RX_LEGACY_CODE_DATA_OUT, .RX_LEGACY_CODE_CTRL_OUT,
        .CTRL_MARK_ERR_OUT, .TX_MARK_START_IN, .TX_MARK_END_IN, .RX_MARK_START_IN, .RX_MARK_END_IN,
        .RX_SLIP_COUNT_FAST_IN, .RX_CODEWORD_OFFSET_IN, .LINK_UP_IN, .CFG_WRITE_IN, .CFG_READ_IN, .CFG_ADDR_IN,
        .CFG_WDATA_IN, .CFG_RDATA_OUT, .CFG_RVALID_OUT, .REFCLK_SELECT_OUT);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(); @(posedge CORE_CLK_IN); #1; endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        n_tests++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        CFG_READ_IN = 1'b1; CFG_ADDR_IN = a; tick(); CFG_READ_IN = 1'b0;
        chk(64'(CFG_RVALID_OUT), 64'h1);
        d = CFG_RDATA_OUT;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(64'(d), 64'(exp));
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        CFG_WRITE_IN = 1'b1; CFG_ADDR_IN = a; CFG_WDATA_IN = d; tick(); CFG_WRITE_IN = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdc(ADDR_TX_DELAY, 32'h0);
        rdc(ADDR_RX_DELAY, 32'h0);
        rdc(ADDR_BLK_SLIP, 32'h0);
        rdc(ADDR_CW_SLIP, 32'h0);
        chk(64'(REFCLK_SELECT_OUT), 64'(REFSEL_RESET));
    endtask
    task automatic t_tx();
        for (int k = 0; k < 4; k++) begin
            kind = 2'(k); tick();
            chk(TX_LINE_DATA_OUT, TX_CLIENT_DATA_IN);
            chk(64'(TX_LINE_CTRL_OUT), 64'(TX_CLIENT_CTRL_IN));
            chk(64'(CTRL_MARK_ERR_OUT), 64'(k == 3));
        end
        LEGACY_MODE_IN = 1'b1; kind = 2'h0; tick();
        chk(TX_LINE_DATA_OUT, {48'h0, TX_LEGACY_CODE_DATA_IN});
        chk(64'(TX_LINE_CTRL_OUT), 64'(TX_LEGACY_CODE_CTRL_IN));
        LEGACY_MODE_IN = 1'b0;
    endtask
    task automatic t_rx();
        RX_LINE_DATA_IN = {56'hA5A5A5A5A5A5A5, CODE_END}; RX_LINE_CTRL_IN = 8'h81; tick();
        chk(RX_CLIENT_DATA_OUT, RX_LINE_DATA_IN);
        chk(64'(RX_CLIENT_CTRL_OUT), 64'h81);
        chk(64'({RX_LEGACY_CODE_CTRL_OUT, RX_LEGACY_CODE_DATA_OUT}), {46'h0, 2'h1, 8'hA5, CODE_END});
        chk(64'(CTRL_MARK_ERR_OUT), 64'h0);
        RX_LINE_CTRL_IN = 8'h80; tick();
        chk(64'(CTRL_MARK_ERR_OUT), 64'h1);
        RX_LINE_CTRL_IN = 8'h01;
    endtask
    // Both markers share the same synchroniser depth, so the span is kept to within one cycle.
    task automatic t_delay();
        logic [31:0] d;
        TX_MARK_START_IN = 1'b1; RX_MARK_START_IN = 1'b1;
        repeat (40) tick();
        TX_MARK_END_IN = 1'b1;
        repeat (60) tick();
        RX_MARK_END_IN = 1'b1;
        repeat (8) tick();
        rd(ADDR_TX_DELAY, d);
        chk_rng(d, 32'h2700, 32'h2900);
        rd(ADDR_RX_DELAY, d);
        chk_rng(d, 32'h6300, 32'h6500);
        {TX_MARK_START_IN, TX_MARK_END_IN, RX_MARK_START_IN, RX_MARK_END_IN} = 4'h0;
    endtask
    task automatic t_slip();
        logic [31:0] d;
        RX_SLIP_COUNT_FAST_IN = 7'h41; RX_CODEWORD_OFFSET_IN = 5'h13; tick();
        LINK_UP_IN = 1'b1;
        repeat (3) tick();
        RX_SLIP_COUNT_FAST_IN = 7'h02; RX_CODEWORD_OFFSET_IN = 5'h04; tick();
        rdc(ADDR_BLK_SLIP, 32'h41);
        rdc(ADDR_CW_SLIP, 32'h13);
        rd(ADDR_BLK_SLIP, d);
        chk(64'((d >= 32'd63) ? (32'd66 - d) : d), 64'h1);
        rd(ADDR_CW_SLIP, d);
        chk(64'((d >= 32'd63) ? (32'd66 - d) : d), 64'h13);
    endtask
    task automatic t_refsel();
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_REFSEL, 32'(i)); tick();
            chk(64'(REFCLK_SELECT_OUT), (i < 5) ? 64'(i) : 64'h4);
        end
        rdc(ADDR_REFSEL, 32'h4);
        rdc(12'h100, 32'h0);
    endtask
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {RST_N_IN, LEGACY_MODE_IN, LINK_UP_IN, CFG_WRITE_IN, CFG_READ_IN} = 5'h0;
        {TX_MARK_START_IN, TX_MARK_END_IN, RX_MARK_START_IN, RX_MARK_END_IN} = 4'h0;
        kind = 2'h1; RX_LINE_DATA_IN = 64'h0; RX_LINE_CTRL_IN = 8'h00; RX_SLIP_COUNT_FAST_IN = 7'h0;
        RX_CODEWORD_OFFSET_IN = 5'h0; CFG_ADDR_IN = 12'h000; CFG_WDATA_IN = 32'h0;
        repeat (20) tick();
        RST_N_IN = 1'b1; tick();
        t_reset(); t_tx(); t_rx(); t_delay(); t_slip(); t_refsel();
        final_report();
    end
    initial begin
        #100000;
        fails++;
        final_report();
    end
endmodule
`default_nettype wire
